/* File: include/shift_move_pkg.sv */
package shift_move_pkg;

  // Register offsets (byte addresses)
  localparam logic [5:0] OFS_OPCODE = 6'h00;
  localparam logic [5:0] OFS_EXTENSION = 6'h04;
  localparam logic [5:0] OFS_SOURCE = 6'h08;
  localparam logic [5:0] OFS_COUNT_SOURCE = 6'h0C;
  localparam logic [5:0] OFS_CONTROL = 6'h10;
  localparam logic [5:0] OFS_RESULT = 6'h14;
  localparam logic [5:0] OFS_OUTCOME = 6'h18;
  localparam logic [5:0] OFS_STATUS_WORD = 6'h1C;
  localparam logic [5:0] OFS_USER_STACK = 6'h20;
  localparam logic [5:0] OFS_VECTOR_BASE = 6'h24;
  localparam logic [5:0] OFS_SOURCE_FC = 6'h28;
  localparam logic [5:0] OFS_DEST_FC = 6'h2C;

  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_DONE_BIT = 1;

  // Status word layout
  localparam logic [15:0] SW_IMPL_MASK = 16'hE71F;
  localparam logic [15:0] SW_RESET_VALUE = 16'h2700;
  localparam int SW_SUPER_BIT = 13;
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  localparam int FLAG_X = 4;
  localparam logic [4:0] FLAG_BYTE_MASK = 5'h1F;

  // Opcode field positions and patterns
  localparam int OP_DIR_BIT = 8;
  localparam int OP_IR_BIT = 5;
  localparam int OP_STACK_DIR_BIT = 3;
  localparam int OP_CTRL_DIR_BIT = 0;
  localparam int EXT_KIND_BIT = 15;
  localparam logic [3:0] OPC_SHIFT_GROUP = 4'hE;
  localparam logic [2:0] SHIFT_MEM_LOGICAL = 3'h1;
  localparam logic [1:0] SHIFT_REG_LOGICAL = 2'h1;
  localparam logic [1:0] SIZE_FIELD_MEMORY = 2'h3;
  localparam logic [9:0] OPC_FROM_STATUS = 10'h103;
  localparam logic [9:0] OPC_FROM_FLAGS = 10'h10B;
  localparam logic [9:0] OPC_TO_FLAGS = 10'h113;
  localparam logic [9:0] OPC_TO_STATUS = 10'h11B;
  localparam logic [11:0] OPC_USER_STACK = 12'h4E6;
  localparam logic [14:0] OPC_CTRL_XFER = 15'h273D;

  localparam logic [2:0] MODE_DATA_REG = 3'h0;
  localparam logic [2:0] MODE_ADDR_REG = 3'h1;
  localparam logic [2:0] MODE_SPECIAL = 3'h7;
  localparam logic [2:0] SPECIAL_LAST_ALT = 3'h1;
  localparam logic [2:0] SPECIAL_LAST_ANY = 3'h4;

  localparam logic [5:0] SHIFT_IMM_ZERO_COUNT = 6'h08;
  localparam logic [5:0] SHIFT_MEM_COUNT = 6'h01;

  // Control register selects
  localparam logic [11:0] CSEL_SOURCE_FC = 12'h000;
  localparam logic [11:0] CSEL_DEST_FC = 12'h001;
  localparam logic [11:0] CSEL_USER_STACK = 12'h800;
  localparam logic [11:0] CSEL_VECTOR_BASE = 12'h801;

  typedef enum logic [1:0] {SZ_NONE, SZ_BYTE, SZ_WORD, SZ_LONG} op_size_t;
  typedef enum logic [1:0] {OUT_OK, OUT_ILLEGAL, OUT_PRIVILEGE} outcome_code_t;
  typedef enum logic [1:0] {DST_NONE, DST_DATA_REG, DST_ADDR_REG, DST_MEMORY} dest_kind_t;
  typedef enum logic [1:0] {EA_ALL, EA_DATA, EA_DATA_ALT, EA_MEM_ALT} ea_class_t;

  typedef struct packed {
    outcome_code_t code;
    dest_kind_t kind;
    logic [2:0] reg_num;
    op_size_t size;
    logic [5:0] ea;
  } outcome_t;

endpackage

/* File: verilog/shift_move_execute.sv */
`timescale 1ns/10ps
module shift_move_execute (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  import shift_move_pkg::*;

  typedef enum {ST_IDLE, ST_SHIFT, ST_FINISH} exec_state_t;

  function automatic logic ea_allowed(input logic [5:0] ea, input ea_class_t cls);
    logic [2:0] mode;
    logic [2:0] rnum;
    mode = ea[5:3];
    rnum = ea[2:0];
    case (mode)
      MODE_DATA_REG: return cls != EA_MEM_ALT;
      MODE_ADDR_REG: return cls == EA_ALL;
      MODE_SPECIAL: begin
        if (cls == EA_DATA_ALT || cls == EA_MEM_ALT) begin
          return rnum <= SPECIAL_LAST_ALT;
        end
        return rnum <= SPECIAL_LAST_ANY;
      end
      default: return 1'b1;
    endcase
  endfunction

  function automatic op_size_t move_size(input logic [1:0] f);
    case (f)
      2'h1: return SZ_BYTE;
      2'h3: return SZ_WORD;
      2'h2: return SZ_LONG;
      default: return SZ_NONE;
    endcase
  endfunction

  function automatic op_size_t shift_size(input logic [1:0] f);
    case (f)
      2'h0: return SZ_BYTE;
      2'h1: return SZ_WORD;
      2'h2: return SZ_LONG;
      default: return SZ_NONE;
    endcase
  endfunction

  function automatic logic [31:0] size_mask(input op_size_t s);
    case (s)
      SZ_BYTE: return 32'h0000_00FF;
      SZ_WORD: return 32'h0000_FFFF;
      default: return 32'hFFFF_FFFF;
    endcase
  endfunction

  function automatic logic [4:0] msb_index(input op_size_t s);
    case (s)
      SZ_BYTE: return 5'h07;
      SZ_WORD: return 5'h0F;
      default: return 5'h1F;
    endcase
  endfunction

  function automatic logic [15:0] logic_flags(input logic [15:0] sw, input logic [31:0] v,
                                              input op_size_t s, input logic x_load,
                                              input logic c_val);
    logic [15:0] r;
    r = sw;
    r[FLAG_N] = v[msb_index(s)];
    r[FLAG_Z] = (v & size_mask(s)) == 32'h0000_0000;
    r[FLAG_V] = 1'b0;
    r[FLAG_C] = c_val;
    if (x_load) begin
      r[FLAG_X] = c_val;
    end
    return r;
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  logic [15:0] opcode_reg;
  logic [15:0] ext_reg;
  logic [31:0] source_reg;
  logic [31:0] count_source_reg;
  logic [15:0] status_word_reg;
  logic [31:0] user_stack_reg;
  logic [31:0] vector_base_reg;
  logic [2:0] source_fc_reg;
  logic [2:0] dest_fc_reg;
  logic [31:0] result_reg;
  outcome_t outcome_reg;
  logic done_reg;
  exec_state_t state_reg;
  logic [31:0] work_reg;
  logic [5:0] shift_cnt_reg;
  logic last_out_reg;
  logic count_zero_reg;
  logic shift_left_reg;
  op_size_t shift_size_reg;
  logic ack_reg;
  logic [31:0] readdata_reg;

  logic bus_req;
  logic bus_write;
  logic start;
  logic supervisor;

  // Decoder results and execute-stage status word write
  outcome_t dec_out;
  logic [31:0] dec_result;
  logic dec_shift;
  logic dec_left;
  logic [5:0] dec_count;
  logic dec_sw_we;
  logic [15:0] dec_sw_value;
  logic dec_stack_we;
  logic dec_ctrl_we;
  logic exec_sw_we;
  logic [15:0] exec_sw_value;

  // Each access is answered on its second edge; the first loads read data
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_reg;
  assign bus_write = avs_write & ack_reg;
  assign avs_readdata = readdata_reg;
  assign supervisor = status_word_reg[SW_SUPER_BIT];
  assign start = bus_write && avs_address == OFS_CONTROL && avs_byteenable[0] &&
                 avs_writedata[CTRL_START_BIT] && state_reg == ST_IDLE;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      readdata_reg <= 32'h0000_0000;
    end else if (avs_read && !ack_reg) begin
      case (avs_address)
        OFS_OPCODE: readdata_reg <= {16'h0000, opcode_reg};
        OFS_EXTENSION: readdata_reg <= {16'h0000, ext_reg};
        OFS_SOURCE: readdata_reg <= source_reg;
        OFS_COUNT_SOURCE: readdata_reg <= count_source_reg;
        OFS_CONTROL: readdata_reg <= {30'h0000_0000, done_reg, state_reg != ST_IDLE};
        OFS_RESULT: readdata_reg <= result_reg;
        OFS_OUTCOME: readdata_reg <= {17'h0_0000, outcome_reg};
        OFS_STATUS_WORD: readdata_reg <= {16'h0000, status_word_reg};
        OFS_USER_STACK: readdata_reg <= user_stack_reg;
        OFS_VECTOR_BASE: readdata_reg <= vector_base_reg;
        OFS_SOURCE_FC: readdata_reg <= {29'h0000_0000, source_fc_reg};
        OFS_DEST_FC: readdata_reg <= {29'h0000_0000, dest_fc_reg};
        default: readdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // Operand registers are frozen while an instruction runs
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      opcode_reg <= 16'h0000;
      ext_reg <= 16'h0000;
      source_reg <= 32'h0000_0000;
      count_source_reg <= 32'h0000_0000;
    end else if (bus_write && state_reg == ST_IDLE) begin
      case (avs_address)
        OFS_OPCODE: opcode_reg <= 16'(be_merge({16'h0000, opcode_reg}, avs_writedata,
                                               avs_byteenable));
        OFS_EXTENSION: ext_reg <= 16'(be_merge({16'h0000, ext_reg}, avs_writedata,
                                               avs_byteenable));
        OFS_SOURCE: source_reg <= be_merge(source_reg, avs_writedata, avs_byteenable);
        OFS_COUNT_SOURCE: count_source_reg <= be_merge(count_source_reg, avs_writedata,
                                                       avs_byteenable);
        default: ;
      endcase
    end
  end

  always_comb begin
    logic [2:0] dmode;
    logic [5:0] src_ea;
    op_size_t sz;
    dmode = opcode_reg[8:6];
    src_ea = opcode_reg[5:0];
    sz = move_size(opcode_reg[13:12]);
    dec_out.code = OUT_ILLEGAL;
    dec_out.kind = DST_NONE;
    dec_out.reg_num = 3'h0;
    dec_out.size = SZ_NONE;
    dec_out.ea = 6'h00;
    dec_result = 32'h0000_0000;
    dec_shift = 1'b0;
    dec_left = opcode_reg[OP_DIR_BIT];
    dec_count = 6'h00;
    dec_sw_we = 1'b0;
    dec_sw_value = status_word_reg;
    dec_stack_we = 1'b0;
    dec_ctrl_we = 1'b0;
    if (opcode_reg[15:12] == OPC_SHIFT_GROUP) begin
      if (opcode_reg[7:6] == SIZE_FIELD_MEMORY) begin
        if (opcode_reg[11:9] == SHIFT_MEM_LOGICAL && ea_allowed(src_ea, EA_MEM_ALT)) begin
          dec_out.code = OUT_OK;
          dec_out.kind = DST_MEMORY;
          dec_out.ea = src_ea;
          dec_out.size = SZ_WORD;
          dec_count = SHIFT_MEM_COUNT;
          dec_shift = 1'b1;
        end
      end else if (opcode_reg[4:3] == SHIFT_REG_LOGICAL) begin
        dec_out.code = OUT_OK;
        dec_out.kind = DST_DATA_REG;
        dec_out.reg_num = opcode_reg[2:0];
        dec_out.size = shift_size(opcode_reg[7:6]);
        dec_shift = 1'b1;
        if (opcode_reg[OP_IR_BIT]) begin
          dec_count = count_source_reg[5:0];
        end else if (opcode_reg[11:9] == 3'h0) begin
          dec_count = SHIFT_IMM_ZERO_COUNT;
        end else begin
          dec_count = {3'h0, opcode_reg[11:9]};
        end
      end
    end else if (opcode_reg[15:14] == 2'h0 && sz != SZ_NONE) begin
      dec_out.size = sz;
      if (dmode == MODE_ADDR_REG) begin
        if (sz != SZ_BYTE && ea_allowed(src_ea, EA_ALL)) begin
          dec_out.code = OUT_OK;
          dec_out.kind = DST_ADDR_REG;
          dec_out.reg_num = opcode_reg[11:9];
          dec_result = sz == SZ_WORD ? {{16{source_reg[15]}}, source_reg[15:0]} : source_reg;
        end
      end else if (ea_allowed(src_ea, EA_ALL) && ea_allowed({dmode, opcode_reg[11:9]}, EA_DATA_ALT) &&
                   !(sz == SZ_BYTE && src_ea[5:3] == MODE_ADDR_REG)) begin
        dec_out.code = OUT_OK;
        dec_out.kind = dmode == MODE_DATA_REG ? DST_DATA_REG : DST_MEMORY;
        dec_out.reg_num = opcode_reg[11:9];
        dec_out.ea = {dmode, opcode_reg[11:9]};
        dec_result = source_reg & size_mask(sz);
        dec_sw_we = 1'b1;
        dec_sw_value = logic_flags(status_word_reg, source_reg, sz, 1'b0, 1'b0);
      end
    end else if (opcode_reg[15:6] == OPC_FROM_FLAGS || opcode_reg[15:6] == OPC_FROM_STATUS) begin
      if (ea_allowed(src_ea, EA_DATA_ALT)) begin
        dec_out.code = OUT_OK;
        dec_out.kind = src_ea[5:3] == MODE_DATA_REG ? DST_DATA_REG : DST_MEMORY;
        dec_out.reg_num = src_ea[2:0];
        dec_out.ea = src_ea;
        dec_out.size = SZ_WORD;
        if (opcode_reg[15:6] == OPC_FROM_FLAGS) begin
          dec_result = {27'h000_0000, status_word_reg[4:0] & FLAG_BYTE_MASK};
        end else if (supervisor) begin
          dec_result = {16'h0000, status_word_reg & SW_IMPL_MASK};
        end else begin
          dec_out.code = OUT_PRIVILEGE;
        end
      end
    end else if (opcode_reg[15:6] == OPC_TO_FLAGS || opcode_reg[15:6] == OPC_TO_STATUS) begin
      if (ea_allowed(src_ea, EA_DATA)) begin
        dec_out.code = OUT_OK;
        dec_out.size = SZ_WORD;
        if (opcode_reg[15:6] == OPC_TO_FLAGS) begin
          dec_sw_we = 1'b1;
          dec_sw_value = {status_word_reg[15:5], source_reg[4:0]};
        end else if (supervisor) begin
          dec_sw_we = 1'b1;
          dec_sw_value = source_reg[15:0] & SW_IMPL_MASK;
        end else begin
          dec_out.code = OUT_PRIVILEGE;
        end
      end
    end else if (opcode_reg[15:4] == OPC_USER_STACK) begin
      if (!supervisor) begin
        dec_out.code = OUT_PRIVILEGE;
      end else begin
        dec_out.code = OUT_OK;
        dec_out.size = SZ_LONG;
        if (opcode_reg[OP_STACK_DIR_BIT]) begin
          dec_out.kind = DST_ADDR_REG;
          dec_out.reg_num = opcode_reg[2:0];
          dec_result = user_stack_reg;
        end else begin
          dec_stack_we = 1'b1;
        end
      end
    end else if (opcode_reg[15:1] == OPC_CTRL_XFER) begin
      if (!supervisor) begin
        dec_out.code = OUT_PRIVILEGE;
      end else if (ext_reg[11:0] == CSEL_SOURCE_FC || ext_reg[11:0] == CSEL_DEST_FC ||
                   ext_reg[11:0] == CSEL_USER_STACK || ext_reg[11:0] == CSEL_VECTOR_BASE) begin
        dec_out.code = OUT_OK;
        dec_out.size = SZ_LONG;
        if (opcode_reg[OP_CTRL_DIR_BIT]) begin
          dec_ctrl_we = 1'b1;
        end else begin
          dec_out.kind = ext_reg[EXT_KIND_BIT] ? DST_ADDR_REG : DST_DATA_REG;
          dec_out.reg_num = ext_reg[14:12];
          case (ext_reg[11:0])
            CSEL_SOURCE_FC: dec_result = {29'h0000_0000, source_fc_reg};
            CSEL_DEST_FC: dec_result = {29'h0000_0000, dest_fc_reg};
            CSEL_USER_STACK: dec_result = user_stack_reg;
            default: dec_result = vector_base_reg;
          endcase
        end
      end
    end
    if (dec_out.code != OUT_OK) begin
      dec_shift = 1'b0;
      dec_sw_we = 1'b0;
      dec_stack_we = 1'b0;
      dec_ctrl_we = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: state_reg <= start && dec_shift ? ST_SHIFT : ST_IDLE;
        ST_SHIFT: state_reg <= shift_cnt_reg == 6'h00 ? ST_FINISH : ST_SHIFT;
        ST_FINISH: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // One bit per cycle keeps the shifter small; a count of 63 costs 65 cycles
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      work_reg <= 32'h0000_0000;
      shift_cnt_reg <= 6'h00;
      last_out_reg <= 1'b0;
      count_zero_reg <= 1'b0;
      shift_left_reg <= 1'b0;
      shift_size_reg <= SZ_NONE;
    end else if (state_reg == ST_IDLE && start) begin
      work_reg <= source_reg & size_mask(dec_out.size);
      shift_cnt_reg <= dec_count;
      last_out_reg <= 1'b0;
      count_zero_reg <= dec_count == 6'h00;
      shift_left_reg <= dec_left;
      shift_size_reg <= dec_out.size;
    end else if (state_reg == ST_SHIFT && shift_cnt_reg != 6'h00) begin
      shift_cnt_reg <= shift_cnt_reg - 6'h01;
      if (shift_left_reg) begin
        last_out_reg <= work_reg[msb_index(shift_size_reg)];
        work_reg <= {work_reg[30:0], 1'b0} & size_mask(shift_size_reg);
      end else begin
        last_out_reg <= work_reg[0];
        work_reg <= {1'b0, work_reg[31:1]};
      end
    end
  end

  always_comb begin
    exec_sw_we = 1'b0;
    exec_sw_value = status_word_reg;
    if (state_reg == ST_IDLE && start && dec_sw_we) begin
      exec_sw_we = 1'b1;
      exec_sw_value = dec_sw_value;
    end else if (state_reg == ST_FINISH) begin
      exec_sw_we = 1'b1;
      exec_sw_value = logic_flags(status_word_reg, work_reg, shift_size_reg, !count_zero_reg,
                                  last_out_reg & !count_zero_reg);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_word_reg <= SW_RESET_VALUE;
    end else if (exec_sw_we) begin
      status_word_reg <= exec_sw_value;
    end else if (bus_write && state_reg == ST_IDLE && avs_address == OFS_STATUS_WORD) begin
      status_word_reg <= 16'(be_merge({16'h0000, status_word_reg}, avs_writedata,
                                      avs_byteenable)) & SW_IMPL_MASK;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      user_stack_reg <= 32'h0000_0000;
      vector_base_reg <= 32'h0000_0000;
      source_fc_reg <= 3'h0;
      dest_fc_reg <= 3'h0;
    end else if (start && (dec_stack_we || dec_ctrl_we)) begin
      if (dec_stack_we || ext_reg[11:0] == CSEL_USER_STACK) begin
        user_stack_reg <= source_reg;
      end else if (ext_reg[11:0] == CSEL_VECTOR_BASE) begin
        vector_base_reg <= source_reg;
      end else if (ext_reg[11:0] == CSEL_SOURCE_FC) begin
        source_fc_reg <= source_reg[2:0];
      end else begin
        dest_fc_reg <= source_reg[2:0];
      end
    end else if (bus_write && state_reg == ST_IDLE) begin
      case (avs_address)
        OFS_USER_STACK: user_stack_reg <= be_merge(user_stack_reg, avs_writedata,
                                                   avs_byteenable);
        OFS_VECTOR_BASE: vector_base_reg <= be_merge(vector_base_reg, avs_writedata,
                                                     avs_byteenable);
        OFS_SOURCE_FC: source_fc_reg <= avs_byteenable[0] ? avs_writedata[2:0] : source_fc_reg;
        OFS_DEST_FC: dest_fc_reg <= avs_byteenable[0] ? avs_writedata[2:0] : dest_fc_reg;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      result_reg <= 32'h0000_0000;
      outcome_reg <= '0;
    end else if (start) begin
      result_reg <= dec_result;
      outcome_reg <= dec_out;
    end else if (state_reg == ST_FINISH) begin
      result_reg <= work_reg;
    end
  end

  // Completion beats a software clear in the same cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      done_reg <= 1'b0;
    end else if ((start && !dec_shift) || state_reg == ST_FINISH) begin
      done_reg <= 1'b1;
    end else if (start) begin
      done_reg <= 1'b0;
    end else if (bus_write && avs_address == OFS_CONTROL && avs_byteenable[0] &&
                 avs_writedata[CTRL_DONE_BIT]) begin
      done_reg <= 1'b0;
    end
  end

endmodule

/* File: sim/shift_move_execute_sva.sv */
`timescale 1ns/10ps
module shift_move_execute_sva
  import shift_move_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire logic rd_ok = avs_read && !avs_waitrequest;
  a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("no wait state on first cycle");
  a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest ##1
    (avs_read || avs_write) |-> !avs_waitrequest) else $error("second wait state");
  a_idle_no_wait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("wait while idle");
  a_status_zeros: assert property (rd_ok && avs_address == OFS_STATUS_WORD |->
    (avs_readdata & ~{16'h0, SW_IMPL_MASK}) == 32'h0) else $error("status spare bits");
  a_fc_zeros: assert property (rd_ok && (avs_address == OFS_SOURCE_FC ||
    avs_address == OFS_DEST_FC) |-> avs_readdata[31:3] == 29'h0) else $error("fc spare bits");
  a_outcome_range: assert property (rd_ok && avs_address == OFS_OUTCOME |->
    avs_readdata[14:13] != 2'h3 && avs_readdata[31:15] == 17'h0) else $error("bad outcome");
  a_unmapped_zero: assert property (rd_ok && avs_address >= 6'h30 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_control_bits: assert property (rd_ok && avs_address == OFS_CONTROL |->
    avs_readdata[31:2] == 30'h0) else $error("control spare bits");
  c_illegal: cover property (rd_ok && avs_address == OFS_OUTCOME && avs_readdata[14:13] == 2'h1);
  c_privilege: cover property (rd_ok && avs_address == OFS_OUTCOME && avs_readdata[14:13] == 2'h2);
  c_busy: cover property (rd_ok && avs_address == OFS_CONTROL && avs_readdata[0]);
endmodule
bind shift_move_execute shift_move_execute_sva chk (.sys_clk(sys_clk), .reset_n(reset_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

/* File: sim/avalon_host_model.sv */
`timescale 1ns/10ps
module avalon_host_model (
  input wire logic sys_clk,
  output logic [5:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  initial begin
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
  end
  // Request held until waitrequest is seen low at a rising edge
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_writedata <= ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask
endmodule

/* File: sim/shift_move_execute_tb.sv */
`timescale 1ns/10ps
module shift_move_execute_tb;
  import shift_move_pkg::*;
  typedef struct {logic [15:0] op; logic [15:0] ext; logic [31:0] src; logic [31:0] cnt;
    logic [31:0] res; logic [15:0] sw; logic [1:0] code;} step_t;
  localparam logic [31:0] NR = 32'hX;
  step_t steps [0:18] = '{
    '{16'hE108, 16'h0, 32'hFF, 32'h0, 32'h0, 16'h2715, 2'h0},
    '{16'hE248, 16'h0, 32'h8001, 32'h0, 32'h4000, 16'h2711, 2'h0},
    '{16'hE3A8, 16'h0, 32'h80000000, 32'h40, 32'h80000000, 16'h2718, 2'h0},
    '{16'hE3D0, 16'h0, 32'hC000, 32'h0, 32'h8000, 16'h2719, 2'h0},
    '{16'hE3C0, 16'h0, 32'hC000, 32'h0, NR, 16'h2719, 2'h1},
    '{16'h1401, 16'h0, 32'h80, 32'h0, 32'h80, 16'h2718, 2'h0},
    '{16'h3440, 16'h0, 32'h8000, 32'h0, 32'hFFFF8000, 16'h2718, 2'h0},
    '{16'h1008, 16'h0, 32'h1, 32'h0, NR, 16'h2718, 2'h1},
    '{16'h44C0, 16'h0, 32'hFF0A, 32'h0, NR, 16'h270A, 2'h0},
    '{16'h42C0, 16'h0, 32'h0, 32'h0, 32'h000A, 16'h270A, 2'h0},
    '{16'h4E7B, 16'h0801, 32'h12345678, 32'h0, NR, 16'h270A, 2'h0},
    '{16'h4E7B, 16'h0002, 32'h0, 32'h0, NR, 16'h270A, 2'h1},
    '{16'h4E7A, 16'h0000, 32'h0, 32'h0, 32'h5, 16'h270A, 2'h0},
    '{16'h4E60, 16'h0, 32'hCAFE0000, 32'h0, NR, 16'h270A, 2'h0},
    '{16'h4E68, 16'h0, 32'h0, 32'h0, 32'hCAFE0000, 16'h270A, 2'h0},
    '{16'h46C0, 16'h0, 32'h0005, 32'h0, NR, 16'h0005, 2'h0},
    '{16'h40C0, 16'h0, 32'h0, 32'h0, NR, 16'h0005, 2'h2},
    '{16'h4E7B, 16'h0801, 32'h0, 32'h0, NR, 16'h0005, 2'h2},
    '{16'hE3A8, 16'h0, 32'h20000001, 32'h43, 32'h8, 16'h0011, 2'h0}};
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [5:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [31:0] d;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int n;
  shift_move_execute dut (.sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  avalon_host_model host (.sys_clk(sys_clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp, input string what);
    logic [31:0] v;
    host.rd(a, v);
    chk(what, exp, v);
  endtask
  initial forever #2 sys_clk = ~sys_clk;
  // Longest shift is 65 cycles; whole run needs under a thousand
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      final_report();
    end
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd_chk(OFS_STATUS_WORD, 32'h2700, "reset status");
    host.wr(OFS_SOURCE_FC, 32'h5);
    foreach (steps[i]) begin
      host.wr(OFS_SOURCE, steps[i].src);
      host.wr(OFS_COUNT_SOURCE, steps[i].cnt);
      host.wr(OFS_OPCODE, {16'h0, steps[i].op});
      host.wr(OFS_EXTENSION, {16'h0, steps[i].ext});
      host.wr(OFS_CONTROL, 32'h1);
      n = 0;
      do begin
        host.rd(OFS_CONTROL, d);
        n++;
      end while (d[1] !== 1'b1 && n < 100);
      chk("control done", 32'h2, d);
      host.rd(OFS_OUTCOME, d);
      chk("outcome code", {30'h0, steps[i].code}, {30'h0, d[14:13]});
      if (steps[i].res !== NR) rd_chk(OFS_RESULT, steps[i].res, "result");
      rd_chk(OFS_STATUS_WORD, {16'h0, steps[i].sw}, "status");
      $display("test %0d done", i);
    end
    rd_chk(OFS_VECTOR_BASE, 32'h12345678, "vector base");
    rd_chk(OFS_USER_STACK, 32'hCAFE0000, "user stack");
    rd_chk(6'h30, 32'h0, "unmapped");
    final_report();
  end
endmodule
